// *** rtl/dcf_fifo.sv ***
// Dual clock pin FIFO: a storage buffer with Gray pointer crossing and a top level
// that samples the write and read pin clocks, serves flags and an APB register file.
// Assumes clk runs at least four times faster than either pin clock.
//
// Functional notes
// RL1: Storage depth is a build parameter, 64 up to 4096 words of 8 bits.
// RL2: Eight bit write data in, eight bit read data out.
// RL3: Reset clears both pointers; full and almost-full high, empty and almost-empty low.
// RL4: Controlling logic must reset the buffer after power-up before writing.
// RL5: Write clock rise with write enable low stores the word and advances.
// RL6: Writes while full are ignored; contents and write pointer stay.
// RL7: Read clock rise with read enable low presents the word and advances.
// RL8: Reads while empty are ignored; read pointer and output register stay.
// RL9: Output bus is driven only while output enable is low.
// RL10: Empty flag low when nothing stored, produced on the read side.
// RL11: Full flag low when every location holds data, produced on the write side.
// RL12: Almost-empty flag low within seven words of empty, read side.
// RL13: Almost-full flag low within seven words of full, write side.
// RL14: Works with read and write clocks tied or fully asynchronous.
// RL15: A written word reaches the read port without extra staging registers.
// RL16: The producer supplies a free-running write clock and gates with enable only.
// RL17: Almost-empty low at seven or fewer words; almost-full at seven or fewer free.
// RL18: Pointers cross sides as Gray code through two-stage synchronisers.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module dcf_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  input wire logic clear,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic [AW:0] wr_count,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] rd_count
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin;
  logic [AW:0] rbin;
  logic [AW:0] wgray;
  logic [AW:0] rgray;
  logic [AW:0] wg_s1;
  logic [AW:0] wg_s2;
  logic [AW:0] rg_s1;
  logic [AW:0] rg_s2;
  logic [AW:0] next_wbin;
  logic [AW:0] next_rbin;
  logic do_push;
  logic do_pop;

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  assign next_wbin = wbin + 1'b1;
  assign next_rbin = rbin + 1'b1;
  // Full compares against the synchronised read pointer, so it may stay late, never early.
  assign in_ready = (wgray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]}); // RL11
  assign out_valid = (rgray != wg_s2); // RL10
  assign do_push = in_valid && in_ready; // RL6
  assign do_pop = out_ready && out_valid; // RL8
  assign wr_count = wbin - gray2bin(rg_s2);
  assign rd_count = gray2bin(wg_s2) - rbin;
  assign out_data = mem[rbin[AW-1:0]]; // RL15

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wbin <= '0;
      wgray <= '0;
    end else if (clear) begin
      wbin <= '0; // RL3
      wgray <= '0;
    end else if (do_push) begin
      wbin <= next_wbin; // RL5
      wgray <= bin2gray(next_wbin); // RL18
    end
  end

  always_ff @(posedge clk) begin
    if (do_push && !clear) begin
      mem[wbin[AW-1:0]] <= in_data; // RL5
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rbin <= '0;
      rgray <= '0;
    end else if (clear) begin
      rbin <= '0; // RL3
      rgray <= '0;
    end else if (do_pop) begin
      rbin <= next_rbin; // RL7
      rgray <= bin2gray(next_rbin); // RL18
    end
  end

  // Each side sees the other's pointer through two flip-flops.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wg_s1 <= '0;
      wg_s2 <= '0;
      rg_s1 <= '0;
      rg_s2 <= '0;
    end else if (clear) begin
      wg_s1 <= '0;
      wg_s2 <= '0;
      rg_s1 <= '0;
      rg_s2 <= '0;
    end else begin
      wg_s1 <= wgray; // RL18
      wg_s2 <= wg_s1;
      rg_s1 <= rgray; // RL18
      rg_s2 <= rg_s1;
    end
  end

endmodule : dcf_buffer

module dcf_top
  import dcf_pkg::*;
#(
  parameter int DEPTH = dcf_pkg::DCF_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dcf_pkg::DCF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device pins.
  input wire dcf_pkg::dcf_pins_t pins,
  output logic [7:0] read_data_out,
  output logic read_data_oe,
  output dcf_pkg::dcf_flags_t flags
);

  import dcf_pkg::*;

  logic [DCF_PINS_W-1:0] s1;
  logic [DCF_PINS_W-1:0] s2;
  logic [DCF_PINS_W-1:0] s3;
  logic [DCF_PINS_W-1:0] agreed_v;
  dcf_pins_t agreed;
  dcf_pins_t prev;
  logic ctrl_enable;
  logic flush_pulse;
  logic wr_refused;
  logic rd_refused;
  logic pin_clear;
  logic clear;
  logic wr_req;
  logic rd_req;
  logic in_ready;
  logic out_valid;
  logic [7:0] out_data;
  logic [AW:0] wr_count;
  logic [AW:0] rd_count;
  logic [AW:0] free_count;
  logic setup_phase;
  logic wr_acc;
  logic [31:0] next_prdata;

  function automatic logic reg_mapped(input logic [DCF_ADDR_W-1:0] a);
    return (a == DCF_CTRL_OFS) || (a == DCF_STATUS_OFS) ||
           (a == DCF_LEVEL_OFS) || (a == DCF_DEPTH_OFS);
  endfunction : reg_mapped

  // Pin sampling: three flops, and a bit is taken once the second and third agree.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= DCF_PINS_IDLE;
      s2 <= DCF_PINS_IDLE;
      s3 <= DCF_PINS_IDLE;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
    end
  end

  for (genvar i = 0; i < DCF_PINS_W; i++) begin : g_agree
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        agreed_v[i] <= DCF_PINS_IDLE[i];
      end else if (s2[i] == s3[i]) begin
        agreed_v[i] <= s3[i]; // RL14
      end
    end
  end

  assign agreed = dcf_pins_t'(agreed_v);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev <= DCF_PINS_IDLE;
    end else begin
      prev <= agreed;
    end
  end

  // Enables and data are taken from the sample before the clock rise was seen.
  assign pin_clear = !agreed.reset_n; // RL3
  assign clear = pin_clear || flush_pulse;
  assign wr_req = agreed.write_clock && !prev.write_clock && !prev.write_enable_n &&
                  ctrl_enable && !pin_clear; // RL5
  assign rd_req = agreed.read_clock && !prev.read_clock && !prev.read_enable_n &&
                  ctrl_enable && !pin_clear; // RL7

  dcf_buffer #(
    .WIDTH(DCF_DATA_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_buffer (
    .clk(clk),
    .rstn(rstn),
    .clear(clear),
    .in_valid(wr_req),
    .in_ready(in_ready),
    .in_data(prev.write_data_in),
    .wr_count(wr_count),
    .out_valid(out_valid),
    .out_ready(rd_req),
    .out_data(out_data),
    .rd_count(rd_count)
  ); // RL1 RL2

  assign free_count = (AW+1)'(DEPTH) - wr_count;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_data_out <= 8'h00;
    end else if (rd_req && out_valid) begin
      read_data_out <= out_data; // RL7 RL8
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_data_oe <= 1'b0;
    end else begin
      read_data_oe <= !agreed.output_enable_n; // RL9
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags <= DCF_FLAGS_RST; // RL3
    end else if (clear) begin
      flags <= DCF_FLAGS_RST; // RL3
    end else begin
      flags.empty_flag_n <= out_valid; // RL10
      flags.almost_empty_flag_n <= (rd_count > (AW+1)'(DCF_ALMOST_OFS)); // RL12 RL17
      flags.almost_full_flag_n <= (free_count > (AW+1)'(DCF_ALMOST_OFS)); // RL13 RL17
      flags.full_flag_n <= in_ready; // RL11
    end
  end

  // APB: zero wait states; read data is captured in the setup cycle.
  assign setup_phase = psel && !penable;
  assign wr_acc = psel && penable && pwrite && reg_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_mapped(paddr);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_enable <= DCF_CTRL_ENABLE_RST;
      flush_pulse <= 1'b0;
    end else begin
      flush_pulse <= wr_acc && (paddr == DCF_CTRL_OFS) && pwdata[DCF_CTRL_FLUSH_BIT];
      if (wr_acc && (paddr == DCF_CTRL_OFS)) begin
        ctrl_enable <= pwdata[DCF_CTRL_ENABLE_BIT];
      end
    end
  end

  // Refused-request flags: a new event in the clearing cycle keeps the bit set.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_refused <= 1'b0;
      rd_refused <= 1'b0;
    end else begin
      if (wr_req && !in_ready) begin
        wr_refused <= 1'b1; // RL6
      end else if (wr_acc && (paddr == DCF_STATUS_OFS) && pwdata[DCF_STAT_WREF_BIT]) begin
        wr_refused <= 1'b0;
      end
      if (rd_req && !out_valid) begin
        rd_refused <= 1'b1; // RL8
      end else if (wr_acc && (paddr == DCF_STATUS_OFS) && pwdata[DCF_STAT_RREF_BIT]) begin
        rd_refused <= 1'b0;
      end
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      DCF_CTRL_OFS: begin
        next_prdata[DCF_CTRL_ENABLE_BIT] = ctrl_enable;
      end
      DCF_STATUS_OFS: begin
        next_prdata[DCF_STAT_EMPTY_BIT] = flags.empty_flag_n;
        next_prdata[DCF_STAT_AEMPTY_BIT] = flags.almost_empty_flag_n;
        next_prdata[DCF_STAT_AFULL_BIT] = flags.almost_full_flag_n;
        next_prdata[DCF_STAT_FULL_BIT] = flags.full_flag_n;
        next_prdata[DCF_STAT_OE_BIT] = read_data_oe;
        next_prdata[DCF_STAT_WREF_BIT] = wr_refused;
        next_prdata[DCF_STAT_RREF_BIT] = rd_refused;
      end
      DCF_LEVEL_OFS: begin
        next_prdata = 32'(rd_count);
      end
      DCF_DEPTH_OFS: begin
        next_prdata = 32'(DEPTH);
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_prdata;
    end
  end

endmodule : dcf_top

`default_nettype wire

// *** shared/dcf_pkg.sv ***
// Constants, pin bundles and the register map for the dual clock pin FIFO.
// Assumes one system clock samples all pins; nothing outside this package.
package dcf_pkg;

  localparam int DCF_DATA_W = 8;
  localparam int DCF_DEPTH = 64;
  localparam int DCF_BUF_DEPTH = 16;
  localparam int DCF_ALMOST_OFS = 7;
  localparam int DCF_ADDR_W = 12;

  localparam logic [11:0] DCF_CTRL_OFS = 12'h000;
  localparam logic [11:0] DCF_STATUS_OFS = 12'h004;
  localparam logic [11:0] DCF_LEVEL_OFS = 12'h008;
  localparam logic [11:0] DCF_DEPTH_OFS = 12'h00C;

  localparam int DCF_CTRL_ENABLE_BIT = 0;
  localparam int DCF_CTRL_FLUSH_BIT = 1;
  localparam logic DCF_CTRL_ENABLE_RST = 1'b1;

  localparam int DCF_STAT_EMPTY_BIT = 0;
  localparam int DCF_STAT_AEMPTY_BIT = 1;
  localparam int DCF_STAT_AFULL_BIT = 2;
  localparam int DCF_STAT_FULL_BIT = 3;
  localparam int DCF_STAT_OE_BIT = 4;
  localparam int DCF_STAT_WREF_BIT = 8;
  localparam int DCF_STAT_RREF_BIT = 9;

  typedef struct packed {
    logic write_clock;
    logic read_clock;
    logic write_enable_n;
    logic read_enable_n;
    logic output_enable_n;
    logic reset_n;
    logic [7:0] write_data_in;
  } dcf_pins_t;

  localparam int DCF_PINS_W = $bits(dcf_pins_t);

  localparam dcf_pins_t DCF_PINS_IDLE = '{
    write_clock: 1'b0,
    read_clock: 1'b0,
    write_enable_n: 1'b1,
    read_enable_n: 1'b1,
    output_enable_n: 1'b1,
    reset_n: 1'b1,
    write_data_in: 8'h00
  };

  typedef struct packed {
    logic empty_flag_n;
    logic almost_empty_flag_n;
    logic almost_full_flag_n;
    logic full_flag_n;
  } dcf_flags_t;

  localparam dcf_flags_t DCF_FLAGS_RST = '{
    empty_flag_n: 1'b0,
    almost_empty_flag_n: 1'b0,
    almost_full_flag_n: 1'b1,
    full_flag_n: 1'b1
  };

endpackage : dcf_pkg

// *** verification/dcf_pin_agent.sv ***
// Producer and consumer on the FIFO pins, with free-running pin clocks.
// Assumes clk is the system clock; callers use wr/rd tasks and end bursts.
`timescale 1ns/1ps
`default_nettype none
module dcf_pin_agent (
  // System clock.
  input wire logic clk,
  // Pins.
  output dcf_pkg::dcf_pins_t pins,
  input wire logic [7:0] read_data_out
);
  import dcf_pkg::*;
  logic [2:0] wcnt = 3'h0;
  logic [3:0] rcnt = 4'h0;
  logic wen_n = 1'h1;
  logic ren_n = 1'h1;
  logic oe_n = 1'h1;
  logic rs_n = 1'h0;
  logic [7:0] wdata = 8'h00;
  // Periods of 60 ns and 100 ns keep the two sides out of step.
  always @(posedge clk) begin
    wcnt <= (wcnt == 3'h5) ? 3'h0 : wcnt + 3'h1;
    rcnt <= (rcnt == 4'h9) ? 4'h0 : rcnt + 4'h1;
  end
  assign pins = '{write_clock: wcnt >= 3'h3, read_clock: rcnt >= 4'h5,
    write_enable_n: wen_n, read_enable_n: ren_n, output_enable_n: oe_n,
    reset_n: rs_n, write_data_in: wdata};
  initial begin
    repeat (20) @(posedge clk);
    rs_n <= 1'h1;
  end
  task automatic wr(input logic [7:0] d);
    if (wen_n) @(posedge clk iff wcnt == 3'h5);
    wen_n <= 1'h0;
    wdata <= d;
    @(posedge clk iff wcnt == 3'h5);
  endtask : wr
  task automatic wr_end();
    wen_n <= 1'h1;
    wdata <= ~wdata;
  endtask : wr_end
  task automatic rd(output logic [7:0] q);
    if (ren_n) @(posedge clk iff rcnt == 4'h9);
    ren_n <= 1'h0;
    @(posedge clk iff rcnt == 4'h9);
    // The word is launched on the edge that ends the wait, so it is taken one edge later.
    @(posedge clk);
    q = read_data_out;
  endtask : rd
  task automatic rd_end();
    ren_n <= 1'h1;
  endtask : rd_end
  task automatic ctl(input logic oe, input logic rs);
    @(posedge clk);
    oe_n <= oe;
    rs_n <= rs;
  endtask : ctl
endmodule : dcf_pin_agent
`default_nettype wire

// *** verification/dcf_properties.sv ***
// Concurrent checks on the ports of the pin FIFO top level.
// Assumes a bind from the bench; every check runs on clk with rstn as reset.
`timescale 1ns/1ps
`default_nettype none
module dcf_properties #(
  parameter int DEPTH = 64
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // APB side.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Device pins.
  input wire dcf_pkg::dcf_pins_t pins,
  input wire logic [7:0] read_data_out,
  input wire logic read_data_oe,
  input wire dcf_pkg::dcf_flags_t flags
);
  import dcf_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_oe_on;
    !pins.output_enable_n [*8];
  endsequence
  sequence s_oe_off;
    pins.output_enable_n [*8];
  endsequence
  sequence s_pin_rst;
    !pins.reset_n [*8];
  endsequence
  AST_PREADY: assert property (s_access |-> pready)
    else $error("pready low in access cycle");
  AST_SLVERR: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access cycle");
  AST_PRDATA_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved without a read");
  AST_RST_FLAGS: assert property ($rose(rstn) |-> flags == DCF_FLAGS_RST && !read_data_oe)
    else $error("flags wrong after reset");
  AST_PIN_RST: assert property (s_pin_rst |-> flags == DCF_FLAGS_RST)
    else $error("flags wrong during pin reset");
  AST_AE_EMPTY: assert property (!flags.empty_flag_n |-> !flags.almost_empty_flag_n)
    else $error("almost empty high while empty");
  AST_AF_FULL: assert property (!flags.full_flag_n |-> !flags.almost_full_flag_n)
    else $error("almost full high while full");
  AST_OE_ON: assert property (s_oe_on |-> read_data_oe)
    else $error("output not driven");
  AST_OE_OFF: assert property (s_oe_off |-> !read_data_oe)
    else $error("output driven while disabled");
  AST_RD_HOLD: assert property ($changed(read_data_out) && pins.reset_n
    |-> flags.empty_flag_n || $past(flags.empty_flag_n)) else $error("read while empty");
endmodule : dcf_properties
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the pin FIFO top level.
// Assumes the pin agent and the property checker compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dcf_pkg::*;
  localparam int DEPTH = 64;
  localparam int FILL[5] = '{7, 8, 56, 57, 64};
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dcf_pins_t pins;
  logic [7:0] read_data_out;
  logic read_data_oe;
  dcf_flags_t flags;
  int n_mismatch = 0;
  int n_checks = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  dcf_pin_agent agent (.clk(clk), .pins(pins), .read_data_out(read_data_out));
  dcf_top #(.DEPTH(DEPTH)) uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .read_data_out(read_data_out),
    .read_data_oe(read_data_oe), .flags(flags));
  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_flags(input dcf_flags_t got, input dcf_flags_t exp);
    chk_data({28'h0, got}, {28'h0, exp});
  endtask : chk_flags
  function automatic dcf_flags_t exp_flags(input int c);
    return '{empty_flag_n: c > 0, almost_empty_flag_n: c > DCF_ALMOST_OFS,
      almost_full_flag_n: DEPTH - c > DCF_ALMOST_OFS, full_flag_n: c < DEPTH};
  endfunction : exp_flags
  task automatic settle();
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'h1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      close_out();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask : apb
  task automatic t_regs();
    logic [31:0] d;
    logic e;
    apb(1'h1, DCF_DEPTH_OFS, 32'hFFFF_FFFF, d, e);
    apb(1'h0, DCF_DEPTH_OFS, 32'h0, d, e);
    chk_data(d, 32'(DEPTH));
    apb(1'h0, 12'h010, 32'h0, d, e);
    chk_data({d[30:0], e}, 32'h1);
  endtask : t_regs
  task automatic t_stream();
    int c;
    int p;
    logic [7:0] q;
    logic [31:0] d;
    logic e;
    c = 0;
    for (p = 0; p < 5; p++) begin
      while (c < FILL[p]) begin
        agent.wr(8'(c) ^ 8'h5A);
        c++;
      end
      agent.wr_end();
      settle();
      chk_flags(flags, exp_flags(c));
    end
    agent.wr(8'hEE);
    agent.wr_end();
    settle();
    apb(1'h0, DCF_STATUS_OFS, 32'h0, d, e);
    chk_data(32'(d[DCF_STAT_WREF_BIT]), 32'h1);
    for (p = 0; p < 5; p++) begin
      while (c > DEPTH - FILL[p]) begin
        agent.rd(q);
        chk_data(32'(q), 32'(8'(DEPTH - c) ^ 8'h5A));
        c--;
      end
      agent.rd_end();
      settle();
      chk_flags(flags, exp_flags(c));
    end
    agent.rd(q);
    agent.rd_end();
    chk_data(32'(q), 32'(8'(DEPTH - 1) ^ 8'h5A));
    settle();
    apb(1'h0, DCF_STATUS_OFS, 32'h0, d, e);
    chk_data(32'(d[DCF_STAT_RREF_BIT]), 32'h1);
  endtask : t_stream
  task automatic t_pin_rst();
    logic [7:0] q;
    agent.wr(8'h11);
    agent.wr(8'h22);
    agent.wr_end();
    agent.ctl(1'h0, 1'h0);
    settle();
    chk_flags(flags, DCF_FLAGS_RST);
    chk_data(32'(read_data_oe), 32'h1);
    agent.ctl(1'h1, 1'h1);
    settle();
    chk_data(32'(read_data_oe), 32'h0);
    agent.wr(8'h77);
    agent.wr_end();
    settle();
    agent.rd(q);
    agent.rd_end();
    chk_data(32'(q), 32'h77);
  endtask : t_pin_rst
  task automatic t_ctrl();
    logic [31:0] d;
    logic e;
    apb(1'h1, DCF_STATUS_OFS, 32'h0000_0300, d, e);
    agent.wr(8'h31);
    agent.wr(8'h32);
    agent.wr_end();
    settle();
    apb(1'h0, DCF_LEVEL_OFS, 32'h0, d, e);
    chk_data(d, 32'h0000_0002);
    apb(1'h1, DCF_CTRL_OFS, 32'h0000_0003, d, e);
    settle();
    apb(1'h0, DCF_STATUS_OFS, 32'h0, d, e);
    chk_data(d, 32'h0000_000C);
    apb(1'h1, DCF_CTRL_OFS, 32'h0, d, e);
    agent.wr(8'h44);
    agent.wr_end();
    settle();
    apb(1'h0, DCF_LEVEL_OFS, 32'h0, d, e);
    chk_data(d, 32'h0000_0000);
    apb(1'h1, DCF_CTRL_OFS, 32'h0000_0001, d, e);
    apb(1'h0, DCF_CTRL_OFS, 32'h0, d, e);
    chk_data(d, 32'h0000_0001);
  endtask : t_ctrl
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    @(negedge clk);
    chk_flags(flags, DCF_FLAGS_RST);
    settle();
    t_regs();
    t_stream();
    t_pin_rst();
    t_ctrl();
    close_out();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
endmodule : tb_top
bind dcf_top dcf_properties #(.DEPTH(DEPTH)) u_props (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pins(pins), .read_data_out(read_data_out), .read_data_oe(read_data_oe), .flags(flags));
`default_nettype wire
